// ---- gser_status.sv ----
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01 - Requests enabled and service needed: set request flag and assert SRQ.
// R02 - Requests disabled: request flag stays zero, SRQ never asserted.
// R03 - Requests disabled: controller polls unprompted and reads the status code.
// R04 - Controller polls after SRQ; device returns its current status byte.
// R05 - Abnormal flag is one for errors and warnings, zero for normal events.
// R06 - Busy flag is one while busy; a busy idle byte reads 16.
// R07 - Busy whenever internal processing or a waveform acquisition is running.
// R08 - Lowest four status bits carry the reason code.
// R09 - Nothing to report: status code, abnormal and request flags are zero.
// R10 - Power-up finished: normal condition, code 0001.
// R11 - Task completed: normal condition, code 0010.
// R12 - User button pressed: normal condition, code 0011.
// R13 - Unknown command: abnormal, code 0001.
// R14 - Command failed to execute: abnormal, code 0010.
// R15 - Internal functional failure: abnormal, code 0011.
// R16 - Command executed with a problem: abnormal, code 0101.
// R17 - Internal problem, operation continues: warning, code 0110.
// R18 - Every abnormal status carries at least one event code.
// R19 - Single query returns next code; all-events query returns every code.
// R20 - Poll returns the byte and moves its code into the polled register.
// R21 - Requests enabled: unpolled or all-events query returns the special code.
// R22 - Event codes lie in 0 to 999, grouped in hundreds by class.
// R23 - SRQ released once the last pending byte is polled, reasserted for a later condition.
module gser_status
  import gser_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter logic [9:0] SPECIAL_EVENT_CODE = 10'h000
)
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SERVICE_REQUEST_ENABLE,
  input wire logic BUSY_PROCESSING,
  input wire logic ACQ_RUNNING,
  input wire logic EVT_VALID,
  input wire logic [2:0] EVT_KIND,
  input wire logic [9:0] EVT_CODE,
  input wire logic SPOLL_REQ,
  input wire logic EVQ_REQ,
  input wire logic ALLEV_REQ,
  output logic [7:0] STATUS_BYTE,
  output logic SPOLL_DONE,
  output logic EC_VALID,
  output logic [9:0] EC_CODE,
  output logic EC_LAST,
  output logic SRQ_O,
  output logic SRQ_OE_N,
  output logic EVT_DROPPED
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
  localparam logic [AW-1:0] PTR_ONE = AW'(1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [AW-1:0] ptr_inc(logic [AW-1:0] p);
    return (p == PTR_LAST) ? '0 : p + PTR_ONE;
  endfunction : ptr_inc

  function automatic logic [7:0] compose(logic pend, gser_entry_type e,
                                         logic en, logic busy);
    logic [7:0] sb;
    sb = SB_RESET;
    sb[SB_BUSY_BIT] = busy; // R06
    if (pend)
    begin
      sb[SB_SRQ_BIT] = en; // R01 R02
      sb[SB_ABN_BIT] = e.abn; // R05
      sb[3:0] = e.ss; // R08
    end
    return sb; // R09
  endfunction : compose

  // ==========================================================================
  // Event intake
  // ==========================================================================
  gser_evt_if ev ();

  gser_evt_class u_class (
    .clk(REF_CLK),
    .rst(RST),
    .evt_valid(EVT_VALID),
    .evt_kind(gser_kind_type'(EVT_KIND)),
    .evt_code(EVT_CODE),
    .ev(ev.src)
  );

  // ==========================================================================
  // Pending event queue
  // ==========================================================================
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;
  logic pending;
  gser_entry_type head;

  assign pending = (count_q != '0);
  assign push = ev.valid && (count_q != CNT_FULL || pop);
  assign rd_ptr_d = pop ? ptr_inc(rd_ptr_q) : rd_ptr_q;

  always_comb
  begin
    count_d = count_q;
    if (push && !pop)
      count_d = count_q + CNT_ONE;
    else if (pop && !push)
      count_d = count_q - CNT_ONE;
  end

  gser_evt_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(REF_CLK),
    .rst(RST),
    .we(push),
    .waddr(wr_ptr_q),
    .wdata(ev.entry),
    .raddr(rd_ptr_d),
    .rdata_q(head)
  );

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_d;
    end
  end

  // A full queue loses the newest event rather than overwrite an unread one.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      EVT_DROPPED <= 1'b0;
    else
      EVT_DROPPED <= ev.valid && !push;
  end

  // ==========================================================================
  // Busy tracking
  // ==========================================================================
  logic busy_q;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      busy_q <= 1'b0;
    else
      busy_q <= BUSY_PROCESSING || ACQ_RUNNING; // R07
  end

  // ==========================================================================
  // Poll and query decisions
  // ==========================================================================
  gser_qstate_type qstate_q;
  gser_qstate_type qstate_d;
  logic polled_valid_q;
  logic polled_valid_d;
  logic [9:0] polled_code_q;
  logic [9:0] polled_code_d;
  logic ec_valid_d;
  logic [9:0] ec_code_d;
  logic ec_last_d;
  logic spoll_take;

  // Polls win over queries in the same cycle; queries arriving then are lost.
  assign spoll_take = SPOLL_REQ && qstate_q == Q_IDLE;

  always_comb
  begin
    qstate_d = qstate_q;
    polled_valid_d = polled_valid_q;
    polled_code_d = polled_code_q;
    ec_valid_d = 1'b0;
    ec_code_d = EC_RESET;
    ec_last_d = 1'b0;
    pop = 1'b0;
    unique case (qstate_q)
      Q_IDLE:
      begin
        if (spoll_take)
        begin
          polled_valid_d = 1'b1; // R20
          polled_code_d = pending ? head.code : EC_NO_STATUS;
          pop = pending;
        end
        else if (EVQ_REQ)
        begin
          ec_valid_d = 1'b1;
          ec_last_d = 1'b1;
          if (polled_valid_q)
          begin
            ec_code_d = polled_code_q; // R19
            polled_valid_d = 1'b0;
          end
          else if (SERVICE_REQUEST_ENABLE)
            ec_code_d = SPECIAL_EVENT_CODE; // R21
          else if (pending)
          begin
            ec_code_d = head.code; // R19
            pop = 1'b1;
          end
          else
            ec_code_d = EC_NO_STATUS;
        end
        else if (ALLEV_REQ)
        begin
          if (polled_valid_q)
          begin
            ec_valid_d = 1'b1;
            ec_code_d = polled_code_q;
            polled_valid_d = 1'b0;
            if (SERVICE_REQUEST_ENABLE)
              qstate_d = Q_ALL_SEC; // R21
            else if (pending)
              qstate_d = Q_ALL_DRAIN; // R19
            else
              ec_last_d = 1'b1;
          end
          else if (SERVICE_REQUEST_ENABLE)
          begin
            ec_valid_d = 1'b1;
            ec_code_d = SPECIAL_EVENT_CODE; // R21
            ec_last_d = 1'b1;
          end
          else if (pending)
            qstate_d = Q_ALL_DRAIN;
          else
          begin
            ec_valid_d = 1'b1;
            ec_code_d = EC_NO_STATUS;
            ec_last_d = 1'b1;
          end
        end
      end
      Q_ALL_DRAIN:
      begin
        // Status bytes of drained entries are lost, as with consecutive queries.
        ec_valid_d = 1'b1;
        ec_code_d = head.code; // R19
        pop = 1'b1;
        if (count_q == CNT_ONE && !ev.valid)
        begin
          ec_last_d = 1'b1;
          qstate_d = Q_IDLE;
        end
      end
      Q_ALL_SEC:
      begin
        ec_valid_d = 1'b1;
        ec_code_d = SPECIAL_EVENT_CODE; // R21
        ec_last_d = 1'b1;
        qstate_d = Q_IDLE;
      end
      default:
        qstate_d = Q_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
      qstate_q <= Q_IDLE;
    else
      qstate_q <= qstate_d;
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      polled_valid_q <= 1'b0;
      polled_code_q <= EC_RESET;
    end
    else
    begin
      polled_valid_q <= polled_valid_d;
      polled_code_q <= polled_code_d;
    end
  end

  // ==========================================================================
  // Serial poll answer
  // ==========================================================================
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      STATUS_BYTE <= SB_RESET;
      SPOLL_DONE <= 1'b0;
    end
    else
    begin
      SPOLL_DONE <= spoll_take;
      if (spoll_take)
        STATUS_BYTE <= compose(pending, head, SERVICE_REQUEST_ENABLE, busy_q); // R04 R20
    end
  end

  // ==========================================================================
  // Event code answer
  // ==========================================================================
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      EC_VALID <= 1'b0;
      EC_CODE <= EC_RESET;
      EC_LAST <= 1'b0;
    end
    else
    begin
      EC_VALID <= ec_valid_d;
      EC_CODE <= ec_code_d;
      EC_LAST <= ec_last_d;
    end
  end

  // ==========================================================================
  // Service request line
  // ==========================================================================
  // The line is open drain: it only ever pulls low, enabled while requesting.
  // Looking at the next count releases it the cycle the last pending byte is polled.
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      SRQ_O <= 1'b0;
      SRQ_OE_N <= 1'b1;
    end
    else
    begin
      SRQ_O <= 1'b0;
      SRQ_OE_N <= !(SERVICE_REQUEST_ENABLE && count_d != '0); // R01 R02 R23
    end
  end

endmodule : gser_status

`default_nettype wire

// ---- gser_pkg.sv ----
package gser_pkg;

  // ==========================================================================
  // Status byte layout
  // ==========================================================================
  localparam int SB_SRQ_BIT = 6;
  localparam int SB_ABN_BIT = 5;
  localparam int SB_BUSY_BIT = 4;
  localparam logic [7:0] SB_RESET = 8'h00;

  // ==========================================================================
  // System status codes
  // ==========================================================================
  localparam logic [3:0] SS_NONE = 4'h0;
  localparam logic [3:0] SS_POWER_ON = 4'h1;
  localparam logic [3:0] SS_OP_DONE = 4'h2;
  localparam logic [3:0] SS_USER_REQ = 4'h3;
  localparam logic [3:0] SS_CMD_ERR = 4'h1;
  localparam logic [3:0] SS_EXEC_ERR = 4'h2;
  localparam logic [3:0] SS_INT_ERR = 4'h3;
  localparam logic [3:0] SS_EXEC_WARN = 4'h5;
  localparam logic [3:0] SS_INT_WARN = 4'h6;

  // ==========================================================================
  // Event code groups
  // ==========================================================================
  localparam logic [9:0] EC_CMD_ERR_BASE = 10'h064;
  localparam logic [9:0] EC_EXEC_ERR_BASE = 10'h0C8;
  localparam logic [9:0] EC_INT_ERR_BASE = 10'h12C;
  localparam logic [9:0] EC_SYSTEM_BASE = 10'h190;
  localparam logic [9:0] EC_EXEC_WARN_BASE = 10'h1F4;
  localparam logic [9:0] EC_INT_WARN_BASE = 10'h258;
  localparam logic [9:0] EC_GROUP_SPAN = 10'h064;
  localparam logic [9:0] EC_NO_STATUS = 10'h190;
  localparam logic [9:0] EC_RESET = 10'h000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    KIND_POWER_ON = 3'b000,
    KIND_OP_DONE = 3'b001,
    KIND_USER_REQ = 3'b010,
    KIND_CMD_ERR = 3'b011,
    KIND_EXEC_ERR = 3'b100,
    KIND_INT_ERR = 3'b101,
    KIND_EXEC_WARN = 3'b110,
    KIND_INT_WARN = 3'b111
  } gser_kind_type;

  typedef struct packed {
    logic abn;
    logic [3:0] ss;
    logic [9:0] code;
  } gser_entry_type;

  typedef enum logic [1:0] {
    Q_IDLE = 2'b00,
    Q_ALL_DRAIN = 2'b01,
    Q_ALL_SEC = 2'b10
  } gser_qstate_type;

endpackage : gser_pkg

// ---- gser_evt_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface gser_evt_if;
  import gser_pkg::*;
  logic valid;
  gser_entry_type entry;
  modport src (output valid, output entry);
  modport dst (input valid, input entry);
endinterface : gser_evt_if

`default_nettype wire

// ---- gser_evt_class.sv ----
`timescale 1ns/1ps
`default_nettype none

module gser_evt_class
  import gser_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic evt_valid,
  input wire gser_kind_type evt_kind,
  input wire logic [9:0] evt_code,
  gser_evt_if.src ev
);

  // ==========================================================================
  // Classification
  // ==========================================================================
  function automatic gser_entry_type classify(gser_kind_type k, logic [9:0] c);
    gser_entry_type e;
    logic [9:0] base;
    e.abn = 1'b1;
    e.ss = SS_NONE;
    base = EC_SYSTEM_BASE;
    unique case (k)
      KIND_POWER_ON: begin e.abn = 1'b0; e.ss = SS_POWER_ON; end
      KIND_OP_DONE: begin e.abn = 1'b0; e.ss = SS_OP_DONE; end
      KIND_USER_REQ: begin e.abn = 1'b0; e.ss = SS_USER_REQ; end
      KIND_CMD_ERR: begin e.ss = SS_CMD_ERR; base = EC_CMD_ERR_BASE; end
      KIND_EXEC_ERR: begin e.ss = SS_EXEC_ERR; base = EC_EXEC_ERR_BASE; end
      KIND_INT_ERR: begin e.ss = SS_INT_ERR; base = EC_INT_ERR_BASE; end
      KIND_EXEC_WARN: begin e.ss = SS_EXEC_WARN; base = EC_EXEC_WARN_BASE; end
      KIND_INT_WARN: begin e.ss = SS_INT_WARN; base = EC_INT_WARN_BASE; end
    endcase
    // A code outside its class group would mislead the controller, so it is
    // replaced by the group's base code.
    if (c < base || c >= base + EC_GROUP_SPAN) // R22
      e.code = base;
    else
      e.code = c; // R18
    return e;
  endfunction : classify

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ev.valid <= 1'b0;
      ev.entry <= '0;
    end
    else
    begin
      ev.valid <= evt_valid;
      ev.entry <= classify(evt_kind, evt_code); // R05 R08 R10 R11 R12 R13 R14 R15 R16 R17
    end
  end

endmodule : gser_evt_class

`default_nettype wire

// ---- gser_evt_mem.sv ----
`timescale 1ns/1ps
`default_nettype none

module gser_evt_mem
  import gser_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire gser_entry_type wdata,
  input wire logic [AW-1:0] raddr,
  output gser_entry_type rdata_q
);

  gser_entry_type mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // Bypass keeps the head entry correct when a write lands on the slot read.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    else if (we && waddr == raddr)
      rdata_q <= wdata;
    else
      rdata_q <= mem[raddr];
  end

endmodule : gser_evt_mem

`default_nettype wire

// ---- gser_status_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Port checker
// ==========================================================================
module gser_status_monitor (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic SERVICE_REQUEST_ENABLE,
  input wire logic BUSY_PROCESSING,
  input wire logic ACQ_RUNNING,
  input wire logic SPOLL_REQ,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic SPOLL_DONE,
  input wire logic EC_VALID,
  input wire logic [9:0] EC_CODE,
  input wire logic EC_LAST,
  input wire logic SRQ_O,
  input wire logic SRQ_OE_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  srq_disabled_a: assert property ((!SERVICE_REQUEST_ENABLE) [*3] |-> SRQ_OE_N)
    else $error("request line pulled with requests disabled");
  flag_disabled_a: assert property ((!SERVICE_REQUEST_ENABLE) [*8] ##0 SPOLL_DONE
    |-> !STATUS_BYTE[6]) else $error("request flag set with requests disabled");
  request_flag_a: assert property (SPOLL_DONE && $past(!SRQ_OE_N) |-> STATUS_BYTE[6])
    else $error("requesting byte polled without request flag");
  poll_answer_a: assert property (SPOLL_DONE |-> $past(SPOLL_REQ))
    else $error("poll answer without a poll");
  byte_holds_a: assert property (!SPOLL_DONE |-> $stable(STATUS_BYTE))
    else $error("status byte changed outside a poll");
  busy_seen_a: assert property ((BUSY_PROCESSING || ACQ_RUNNING) [*3] ##0 SPOLL_DONE
    |-> STATUS_BYTE[4]) else $error("busy flag missing while busy");
  idle_clear_a: assert property ((!BUSY_PROCESSING && !ACQ_RUNNING) [*3] ##0 SPOLL_DONE
    |-> !STATUS_BYTE[4]) else $error("busy flag set while idle");
  code_idle_a: assert property (!EC_VALID |-> EC_CODE == 10'h000)
    else $error("event code shown without valid");
  last_word_a: assert property (EC_LAST |-> EC_VALID)
    else $error("last marker without a word");
  code_range_a: assert property (EC_VALID |-> EC_CODE <= 10'h3E7)
    else $error("event code above 999");
  line_low_a: assert property (!SRQ_OE_N |-> !SRQ_O)
    else $error("request line driven high while enabled");
endmodule : gser_status_monitor

bind gser_status gser_status_monitor mon (.REF_CLK, .RST, .SERVICE_REQUEST_ENABLE,
  .BUSY_PROCESSING, .ACQ_RUNNING, .SPOLL_REQ, .STATUS_BYTE, .SPOLL_DONE, .EC_VALID,
  .EC_CODE, .EC_LAST, .SRQ_O, .SRQ_OE_N);

`default_nettype wire

// ---- gser_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Bus controller model
// ==========================================================================
module gser_ctrl_model (
  input wire logic clk,
  input wire logic srq_oe_n,
  input wire logic auto_poll,
  input wire logic poll_cmd,
  input wire logic evq_cmd,
  input wire logic allev_cmd,
  output logic spoll_req,
  output logic evq_req,
  output logic allev_req
);
  logic auto_q = 1'b0;
  logic [1:0] hold_q = 2'h0;

  // The hold-off lets the released request line settle before it is read again.
  always @(negedge clk)
  begin
    auto_q <= 1'b0;
    if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
    else if (auto_poll && !srq_oe_n)
    begin
      auto_q <= 1'b1;
      hold_q <= 2'h3;
    end
  end

  assign spoll_req = poll_cmd | auto_q;
  assign evq_req = evq_cmd;
  assign allev_req = allev_cmd;
endmodule : gser_ctrl_model

`default_nettype wire

// ---- tb_gpib_status_event_reporter.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Testbench
// ==========================================================================
module tb_gpib_status_event_reporter;
  localparam logic [9:0] SEC = 10'h3E7;
  logic ref_clk = 1'b0;
  logic rst = 1'b1, en = 1'b0, busy = 1'b0, acq = 1'b0, ev = 1'b0;
  logic [2:0] kind = 3'h0;
  logic [9:0] code = 10'h000;
  logic auto = 1'b0, pc = 1'b0, qc = 1'b0, ac = 1'b0;
  logic spoll, evq, allev, done, ecv, ecl, srq_o, srq_n, drop;
  logic [7:0] sb;
  logic [9:0] ecc;
  logic [9:0] ecs [8] = '{10'h191, 10'h192, 10'h193, 10'h09D, 10'h0FC, 10'h15E, 10'h226,
    10'h28A};
  logic [3:0] sss [8] = '{4'h1, 4'h2, 4'h3, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
  int fails = 0, comparisons = 0;

  gser_status #(.DEPTH(8), .SPECIAL_EVENT_CODE(SEC)) uut (.REF_CLK(ref_clk), .RST(rst),
    .SERVICE_REQUEST_ENABLE(en), .BUSY_PROCESSING(busy), .ACQ_RUNNING(acq), .EVT_VALID(ev),
    .EVT_KIND(kind), .EVT_CODE(code), .SPOLL_REQ(spoll), .EVQ_REQ(evq), .ALLEV_REQ(allev),
    .STATUS_BYTE(sb), .SPOLL_DONE(done), .EC_VALID(ecv), .EC_CODE(ecc), .EC_LAST(ecl),
    .SRQ_O(srq_o), .SRQ_OE_N(srq_n), .EVT_DROPPED(drop));
  gser_ctrl_model ctrl (.clk(ref_clk), .srq_oe_n(srq_n), .auto_poll(auto), .poll_cmd(pc),
    .evq_cmd(qc), .allev_cmd(ac), .spoll_req(spoll), .evq_req(evq), .allev_req(allev));

  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : chk

  task automatic post(input logic [2:0] k, input logic [9:0] c);
    @(negedge ref_clk);
    ev = 1'b1;
    kind = k;
    code = c;
    @(negedge ref_clk);
    ev = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : post

  task automatic poll(input logic [7:0] exp);
    @(negedge ref_clk);
    pc = 1'b1;
    @(negedge ref_clk);
    pc = 1'b0;
    // The done pulse stands for one cycle only, so it is looked at right here.
    chk("poll done", 10'h001, {9'h000, done});
    chk("status byte", {2'b00, exp}, {2'b00, sb});
  endtask : poll

  task automatic query(input logic all, input logic [9:0] e0, input logic [9:0] e1,
    input int n);
    int i = 0;
    @(negedge ref_clk);
    ac = all;
    qc = !all;
    @(negedge ref_clk);
    ac = 1'b0;
    qc = 1'b0;
    while (ecv !== 1'b1 && i < 4)
    begin
      @(negedge ref_clk);
      i++;
    end
    for (i = 0; i < n; i++)
    begin
      chk("event code", (i == 0) ? e0 : e1, ecc);
      chk("last word", {9'h000, i == n - 1}, {9'h000, ecl});
      @(negedge ref_clk);
    end
  endtask : query

  task automatic wait_done;
    int i = 0;
    do
      @(negedge ref_clk);
    while (done !== 1'b1 && i++ < 20);
  endtask : wait_done

  task automatic t_kinds;
    en = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      post(3'(k), ecs[k]);
      chk("request line", 10'h000, {9'h000, srq_n});
      chk("request data", 10'h000, {9'h000, srq_o});
      poll({2'b01, k >= 3, 1'b0, sss[k]});
      chk("request line", 10'h001, {9'h000, srq_n});
      query(1'b0, ecs[k], ecs[k], 1);
    end
  endtask : t_kinds

  task automatic t_off;
    en = 1'b0;
    post(3'h3, 10'h09D);
    chk("request line", 10'h001, {9'h000, srq_n});
    poll(8'h21);
    query(1'b0, 10'h09D, 10'h09D, 1);
    post(3'h4, 10'h0FC);
    post(3'h5, 10'h15E);
    query(1'b1, 10'h0FC, 10'h15E, 2);
    query(1'b1, 10'h190, 10'h190, 1);
  endtask : t_off

  task automatic t_busy;
    busy = 1'b1;
    repeat (3) @(negedge ref_clk);
    poll(8'h10);
    busy = 1'b0;
    acq = 1'b1;
    repeat (3) @(negedge ref_clk);
    poll(8'h10);
    acq = 1'b0;
    repeat (3) @(negedge ref_clk);
    poll(8'h00);
    query(1'b0, 10'h190, 10'h190, 1);
  endtask : t_busy

  task automatic t_special;
    en = 1'b1;
    post(3'h4, 10'h0FC);
    query(1'b0, SEC, SEC, 1);
    poll(8'h62);
    query(1'b1, 10'h0FC, SEC, 2);
    busy = 1'b1;
    post(3'h3, 10'h09D);
    poll(8'h71);
    busy = 1'b0;
    query(1'b0, 10'h09D, 10'h09D, 1);
  endtask : t_special

  // Back-to-back events are both polled automatically in turn, so the line must end up released.
  task automatic t_auto;
    auto = 1'b1;
    @(negedge ref_clk);
    ev = 1'b1;
    kind = 3'h3;
    code = 10'h09D;
    @(negedge ref_clk);
    kind = 3'h4;
    code = 10'h0FC;
    @(negedge ref_clk);
    ev = 1'b0;
    wait_done;
    chk("auto byte", 10'h061, {2'b00, sb});
    wait_done;
    chk("auto byte", 10'h062, {2'b00, sb});
    repeat (4) @(negedge ref_clk);
    chk("request line", 10'h001, {9'h000, srq_n});
    auto = 1'b0;
    query(1'b0, 10'h0FC, 10'h0FC, 1);
  endtask : t_auto

  // Nine back-to-back events with a foreign code: the base comes back and the ninth is lost.
  task automatic t_full;
    en = 1'b0;
    @(negedge ref_clk);
    ev = 1'b1;
    kind = 3'h4;
    code = 10'h064;
    repeat (9) @(negedge ref_clk);
    ev = 1'b0;
    @(negedge ref_clk);
    chk("event dropped", 10'h001, {9'h000, drop});
    query(1'b1, 10'h0C8, 10'h0C8, 8);
    query(1'b1, 10'h190, 10'h190, 1);
  endtask : t_full

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  initial
  begin
    #1000000;
    fails++;
    stop_test;
  end

  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk("idle request line", 10'h001, {9'h000, srq_n});
    chk("idle byte", 10'h000, {2'b00, sb});
    t_kinds;
    t_off;
    t_busy;
    t_special;
    t_auto;
    t_full;
    stop_test;
  end
endmodule : tb_gpib_status_event_reporter

`default_nettype wire
